// *** hdl/addr_map_pkg.sv ***
// constants and types for the cpu address map decoder
package addr_map_pkg;

  // physical address width and register port
  localparam int unsigned PHYS_W    = 26;
  localparam int unsigned REG_AW    = 4;
  localparam int unsigned PIN_GRP_N = 5;

  // register indices on the register port
  localparam logic [3:0] REG_CALL_TABLE_BASE_POINTER_OFF   = 4'h0;
  localparam logic [3:0] REG_PINSEL_OFF = 4'h1;
  localparam logic [3:0] REG_CFG_OFF    = 4'h2;
  localparam logic [3:0] REG_STATUS_OFF = 4'h3;
  localparam logic [3:0] REG_PC_OFF     = 4'h4;

  // table base pointer: bit 0 and bits 31..26 read as zero
  localparam logic [31:0] CALL_TABLE_BASE_POINTER_WMASK = 32'h03ff_fffe;
  localparam logic [31:0] CALL_TABLE_BASE_POINTER_RESET = 32'h0000_0000;

  // program counter keeps the low 26 bits only
  localparam logic [31:0] PC_MASK     = 32'h03ff_ffff;
  localparam logic [31:0] RESET_ENTRY = 32'h0000_0000;

  // pin function select bits, 0 = port mode, 1 = control mode
  localparam int unsigned PIN_DATA_HI = 0;
  localparam int unsigned PIN_DATA_LO = 1;
  localparam int unsigned PIN_CTRL    = 2;
  localparam int unsigned PIN_CS      = 3;
  localparam int unsigned PIN_TIMING  = 4;
  localparam logic [4:0]  PINSEL_RESET = 5'h00;

  // configuration register fields
  localparam int unsigned CFG_LARGE   = 0;
  localparam int unsigned CFG_ROM96   = 1;
  localparam logic [1:0]  CFG_RESET   = 2'h0;

  // status register fields
  localparam int unsigned STAT_FAULT  = 8;

  // region boundaries of the physical map
  localparam logic [25:0] ROM_TOP       = 26'h0f_ffff;
  localparam logic [25:0] ROM_LIM_128K  = 26'h01_ffff;
  localparam logic [25:0] ROM_LIM_96K   = 26'h01_7fff;
  localparam logic [25:0] CS0_BASE      = 26'h10_0000;
  localparam logic [25:0] CS1_BASE      = 26'h20_0000;
  localparam logic [25:0] CS2_BASE      = 26'h40_0000;
  localparam logic [25:0] CS3_BASE      = 26'h80_0000;
  localparam logic [25:0] EXT_TOP       = 26'hff_ffff;
  localparam logic [25:0] RAM_BASE      = 26'h3ff_0000;
  localparam logic [25:0] PERIPH_BASE   = 26'h3ff_f000;

  // access kinds from the core
  typedef enum logic [1:0] {
    KIND_FETCH = 2'b00,
    KIND_READ  = 2'b01,
    KIND_WRITE = 2'b10,
    KIND_IDLE  = 2'b11
  } acc_kind_t;

  // decoded target region
  typedef enum logic [3:0] {
    RG_NONE   = 4'b0000,
    RG_ROM    = 4'b0001,
    RG_RAM    = 4'b0010,
    RG_PERIPH = 4'b0011,
    RG_EXT0   = 4'b0100,
    RG_EXT1   = 4'b0101,
    RG_EXT2   = 4'b0110,
    RG_EXT3   = 4'b0111,
    RG_EXTROM = 4'b1000
  } region_t;

endpackage

// *** hdl/addr_region_decode.sv ***
// combinational region decoder for one 26-bit physical address
`timescale 1ns/100ps
`default_nettype none
module addr_region_decode
  import addr_map_pkg::*;
(
  input  wire logic [25:0] phys_in,
  input  wire acc_kind_t   kind_in,
  input  wire logic        large_in,
  input  wire logic        rom96_in,
  output region_t          region_out,
  output logic             fetch_bad_out
);

  logic [25:0] rom_lim;

  // implemented rom size for the variant
  assign rom_lim = rom96_in ? ROM_LIM_96K : ROM_LIM_128K;

  // address to region
  always_comb begin
    region_out    = RG_NONE;
    fetch_bad_out = 1'b0;
    if (phys_in <= ROM_TOP) begin
      if (kind_in == KIND_WRITE) begin
        region_out = RG_EXTROM;
      end else if (phys_in <= rom_lim) begin
        region_out = RG_ROM;
      end else begin
        region_out = RG_NONE;
      end
    end else if (phys_in < CS1_BASE) begin
      region_out = RG_EXT0;
    end else if (phys_in < CS2_BASE) begin
      region_out = RG_EXT1;
    end else if (phys_in < CS3_BASE) begin
      region_out = large_in ? RG_EXT2 : RG_NONE;
    end else if (phys_in <= EXT_TOP) begin
      region_out = large_in ? RG_EXT3 : RG_NONE;
    end else if (phys_in < RAM_BASE) begin
      region_out = RG_NONE;
    end else if (phys_in < PERIPH_BASE) begin
      region_out = RG_RAM;
    end else begin
      if (kind_in == KIND_FETCH) begin
        fetch_bad_out = 1'b1;
      end else begin
        region_out = RG_PERIPH;
      end
    end
  end

endmodule // addr_region_decode
`default_nettype wire

// *** hdl/cpu_address_map_decoder.sv ***
// cpu address masking, wraparound and memory map decode
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module cpu_address_map_decoder
  import addr_map_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [31:0]      reg_rdata_out,
  input  wire logic        acc_valid_in,
  input  wire logic [1:0]  acc_kind_in,
  input  wire logic [31:0] acc_base_in,
  input  wire logic [31:0] acc_disp_in,
  output logic [25:0]      mem_addr_out,
  output logic             rom_sel_out,
  output logic             ram_sel_out,
  output logic             periph_sel_out,
  output logic [3:0]       ext_sel_out,
  output logic             ext_area_out,
  output logic             mem_rd_out,
  output logic             mem_wr_out,
  output logic             prohibited_out,
  output logic             fetch_fault_out,
  output logic [31:0]      pc_out,
  output logic [31:0]      call_table_base_pointer_out,
  output logic [4:0]       pin_func_out
);

  // one-hot external select for a region, zero for the rest
  function automatic logic [3:0] ext_onehot(input region_t rg);
    case (rg)
      RG_EXT0: ext_onehot = 4'h1;
      RG_EXT1: ext_onehot = 4'h2;
      RG_EXT2: ext_onehot = 4'h4;
      RG_EXT3: ext_onehot = 4'h8;
      default: ext_onehot = 4'h0;
    endcase
  endfunction

  logic [31:0] call_table_base_pointer_ff;
  logic [4:0]  pinsel_ff;
  logic [1:0]  cfg_ff;
  logic        fault_ff;
  logic [31:0] pc_ff;
  region_t     last_region_ff;
  logic [31:0] rdata_ff;
  logic [25:0] addr_ff;
  logic        rom_sel_ff;
  logic        ram_sel_ff;
  logic        periph_sel_ff;
  logic [3:0]  ext_sel_ff;
  logic        ext_area_ff;
  logic        rd_ff;
  logic        wr_ff;
  logic        prohib_ff;
  logic        ffault_ff;

  logic [31:0] acc_sum;
  logic [25:0] phys;
  acc_kind_t   kind;
  region_t     region;
  logic        fetch_bad;
  logic        ext_blocked;
  logic        nxt_prohib;
  logic        acc_live;
  logic [31:0] nxt_rdata;

  // address forming: 32-bit wrap, then 26-bit physical image
  assign acc_sum  = acc_base_in + acc_disp_in;
  assign phys     = acc_sum[25:0];
  assign kind     = acc_kind_t'(acc_kind_in);
  assign acc_live = acc_valid_in && (kind != KIND_IDLE);

  addr_region_decode u_decode (
    .phys_in       (phys),
    .kind_in       (kind),
    .large_in      (cfg_ff[CFG_LARGE]),
    .rom96_in      (cfg_ff[CFG_ROM96]),
    .region_out    (region),
    .fetch_bad_out (fetch_bad)
  );

  // external selects stay off while the select pins are in port mode
  assign ext_blocked = (ext_onehot(region) != 4'h0) && !pinsel_ff[PIN_CS];
  assign nxt_prohib  = (region == RG_NONE) || ext_blocked;

  // table base pointer, masked on write
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      call_table_base_pointer_ff <= CALL_TABLE_BASE_POINTER_RESET;
    end else if (reg_wr_in && reg_addr_in == REG_CALL_TABLE_BASE_POINTER_OFF) begin
      call_table_base_pointer_ff <= reg_wdata_in & CALL_TABLE_BASE_POINTER_WMASK;
    end
  end

  // pin function select, port mode after reset
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pinsel_ff <= PINSEL_RESET;
    end else if (reg_wr_in && reg_addr_in == REG_PINSEL_OFF) begin
      pinsel_ff <= reg_wdata_in[4:0];
    end
  end

  // variant configuration
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cfg_ff <= CFG_RESET;
    end else if (reg_wr_in && reg_addr_in == REG_CFG_OFF) begin
      cfg_ff <= reg_wdata_in[1:0];
    end
  end

  // sticky fault flag, write one clears, a new fault wins
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fault_ff <= 1'b0;
    end else if (acc_live && (nxt_prohib || fetch_bad)) begin
      fault_ff <= 1'b1;
    end else if (reg_wr_in && reg_addr_in == REG_STATUS_OFF
                 && reg_wdata_in[STAT_FAULT]) begin
      fault_ff <= 1'b0;
    end
  end

  // program counter follows every fetch except a peripheral-area one, starts at reset entry
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pc_ff <= RESET_ENTRY;
    end else if (acc_live && kind == KIND_FETCH && !fetch_bad) begin
      pc_ff <= acc_sum & PC_MASK;
    end
  end

  // last decoded region for status
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      last_region_ff <= RG_NONE;
    end else if (acc_live) begin
      last_region_ff <= region;
    end
  end

  // register read mux
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (reg_addr_in)
      REG_CALL_TABLE_BASE_POINTER_OFF:   nxt_rdata = call_table_base_pointer_ff;
      REG_PINSEL_OFF: nxt_rdata = {27'h0, pinsel_ff};
      REG_CFG_OFF:    nxt_rdata = {30'h0, cfg_ff};
      REG_STATUS_OFF: nxt_rdata = {23'h0, fault_ff, 4'h0, last_region_ff};
      REG_PC_OFF:     nxt_rdata = pc_ff;
      default:        nxt_rdata = 32'h0000_0000;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_ff <= 32'h0000_0000;
    end else if (reg_rd_in) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 32'h0000_0000;
    end
  end

  // registered selects, one cycle after the request
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      addr_ff       <= 26'h000_0000;
      rom_sel_ff    <= 1'b0;
      ram_sel_ff    <= 1'b0;
      periph_sel_ff <= 1'b0;
      ext_sel_ff    <= 4'h0;
      ext_area_ff   <= 1'b0;
      rd_ff         <= 1'b0;
      wr_ff         <= 1'b0;
      prohib_ff     <= 1'b0;
      ffault_ff     <= 1'b0;
    end else begin
      addr_ff       <= phys;
      rom_sel_ff    <= acc_live && region == RG_ROM;
      ram_sel_ff    <= acc_live && region == RG_RAM;
      periph_sel_ff <= acc_live && region == RG_PERIPH;
      ext_sel_ff    <= (acc_live && !ext_blocked) ? ext_onehot(region) : 4'h0;
      ext_area_ff   <= acc_live && !nxt_prohib && !fetch_bad
                       && (region == RG_EXTROM || ext_onehot(region) != 4'h0);
      rd_ff         <= acc_live && kind != KIND_WRITE && !nxt_prohib && !fetch_bad;
      wr_ff         <= acc_live && kind == KIND_WRITE && !nxt_prohib;
      prohib_ff     <= acc_live && nxt_prohib;
      ffault_ff     <= acc_live && fetch_bad;
    end
  end

  assign reg_rdata_out   = rdata_ff;
  assign mem_addr_out    = addr_ff;
  assign rom_sel_out     = rom_sel_ff;
  assign ram_sel_out     = ram_sel_ff;
  assign periph_sel_out  = periph_sel_ff;
  assign ext_sel_out     = ext_sel_ff;
  assign ext_area_out    = ext_area_ff;
  assign mem_rd_out      = rd_ff;
  assign mem_wr_out      = wr_ff;
  assign prohibited_out  = prohib_ff;
  assign fetch_fault_out = ffault_ff;
  assign pc_out          = pc_ff;
  assign call_table_base_pointer_out        = call_table_base_pointer_ff;
  assign pin_func_out    = pinsel_ff;

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  AST_CALL_TABLE_BASE_POINTER_BIT0: assert property (reg_wr_in && reg_addr_in == REG_CALL_TABLE_BASE_POINTER_OFF
    |=> call_table_base_pointer_out[0] == 1'b0 && call_table_base_pointer_out[25:1] == $past(reg_wdata_in[25:1]))
    else $error("table base bit 0 not zero after write");

  AST_CALL_TABLE_BASE_POINTER_TOP: assert property (reg_rd_in && reg_addr_in == REG_CALL_TABLE_BASE_POINTER_OFF
    |=> reg_rdata_out[31:26] == 6'h00)
    else $error("table base top bits read nonzero");

  AST_PC_TOP: assert property (acc_live && kind == KIND_FETCH && !fetch_bad
    |=> pc_out[31:26] == 6'h00 && pc_out[25:0] == $past(acc_sum[25:0]))
    else $error("program counter top bits not zero");

  AST_PROG_WRAP: assert property (acc_live && kind == KIND_FETCH
    && acc_base_in == 32'h03ff_fffe && acc_disp_in == 32'h0000_0002
    |=> mem_addr_out == 26'h000_0000 && rom_sel_out)
    else $error("program space did not wrap to zero");

  AST_DATA_WRAP: assert property (acc_live && kind == KIND_READ
    |=> mem_addr_out == $past(acc_sum[25:0]))
    else $error("data address carry not dropped");

  AST_DATA_IMAGE: assert property (acc_live && kind == KIND_READ
    && acc_base_in[31:26] != 6'h00 && acc_disp_in == 32'h0000_0000
    |=> mem_addr_out == $past(acc_base_in[25:0]))
    else $error("data image bits not ignored");

  AST_PERIPH: assert property (acc_live && kind != KIND_FETCH
    && phys >= PERIPH_BASE |=> periph_sel_out && !ram_sel_out)
    else $error("peripheral area not selected");

  AST_RAM: assert property (acc_live && phys >= RAM_BASE && phys < PERIPH_BASE
    |=> ram_sel_out ##1 !ram_sel_out || $past(acc_live, 1))
    else $error("ram area not selected");

  AST_CS_HIGH: assert property (acc_live && cfg_ff[CFG_LARGE] && pinsel_ff[PIN_CS]
    && phys >= CS3_BASE && phys <= EXT_TOP |=> ext_sel_out == 4'h8)
    else $error("select three not asserted");

  AST_CS_LOW: assert property (acc_live && pinsel_ff[PIN_CS]
    && phys >= CS0_BASE && phys < CS1_BASE |=> ext_sel_out == 4'h1)
    else $error("select zero not asserted");

  AST_ROM_WRITE: assert property (acc_live && kind == KIND_WRITE
    && phys <= ROM_TOP |=> !rom_sel_out && ext_area_out && mem_wr_out)
    else $error("rom region write not sent external");

  AST_ROM_LIMIT: assert property (acc_live && kind == KIND_READ
    && !cfg_ff[CFG_ROM96] && phys > ROM_LIM_128K && phys <= ROM_TOP
    |=> prohibited_out && !rom_sel_out)
    else $error("rom beyond 128k not prohibited");

  AST_PROHIB: assert property (prohibited_out
    |-> !mem_wr_out && !mem_rd_out && ext_sel_out == 4'h0 && !rom_sel_out)
    else $error("prohibited access still selects");

  COV_FETCH_EXT: cover property (acc_live && kind == KIND_FETCH && phys == CS0_BASE);
  COV_PERIPH_RD: cover property (acc_live && kind == KIND_READ && phys >= PERIPH_BASE);
  COV_FAULT:     cover property (fetch_fault_out);
  COV_ROM_WR:    cover property (acc_live && kind == KIND_WRITE && phys <= ROM_TOP);

endmodule // cpu_address_map_decoder
`default_nettype wire

// *** test/core_access_model.sv ***
// core side model that issues fetch, read and write requests
`timescale 1ns/100ps
`default_nettype none
module core_access_model (
  input  wire logic        clk_in,
  output logic             acc_valid_out,
  output logic [1:0]       acc_kind_out,
  output logic [31:0]      acc_base_out,
  output logic [31:0]      acc_disp_out
);
  // idle until the bench asks for a request
  initial begin
    acc_valid_out = 1'b0;
    acc_kind_out  = 2'b11;
    acc_base_out  = 32'h0000_0000;
    acc_disp_out  = 32'h0000_0000;
  end
  // one request per edge; kind and address pass through unchecked, peripheral fetches included
  task automatic put(input logic v, input logic [1:0] k, input logic [31:0] b, d);
    @(posedge clk_in);
    acc_valid_out <= v;
    acc_kind_out  <= k;
    acc_base_out  <= b;
    acc_disp_out  <= d;
  endtask
endmodule // core_access_model
`default_nettype wire

// *** test/tb_cpu_address_map_decoder.sv ***
// self-checking bench for the cpu address map decoder
`timescale 1ns/100ps
`default_nettype none
module tb_cpu_address_map_decoder;
  import addr_map_pkg::*;
  logic clk_in = 0, rst_b_in = 0, reg_wr_in = 0, reg_rd_in = 0;
  logic [3:0] reg_addr_in = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0000_0000, reg_rdata_out, pc_out, call_table_base_pointer_out;
  logic acc_valid_in, rom_sel_out, ram_sel_out, periph_sel_out, ext_area_out;
  logic [1:0] acc_kind_in;
  logic [31:0] acc_base_in, acc_disp_in;
  logic [25:0] mem_addr_out;
  logic [3:0] ext_sel_out;
  logic mem_rd_out, mem_wr_out, prohibited_out, fetch_fault_out;
  logic [4:0] pin_func_out;
  int error_cnt = 0, total_checks = 0, cyc = 0, seed = 32'ha113d255;
  logic [31:0] pc_exp = 32'h0000_0000;
  logic [25:0] pool [20] = '{26'h0, 26'h1_7fff, 26'h1_8000, 26'h1_ffff, 26'h2_0000,
    26'hf_ffff, 26'h10_0000, 26'h1f_ffff, 26'h20_0000, 26'h3f_ffff, 26'h40_0000,
    26'h7f_ffff, 26'h80_0000, 26'hff_ffff, 26'h100_0000, 26'h3fe_ffff,
    26'h3ff_0000, 26'h3ff_efff, 26'h3ff_f000, 26'h3ff_ffff};
  always #2.5 clk_in = ~clk_in;
  cpu_address_map_decoder dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .acc_valid_in(acc_valid_in),
    .acc_kind_in(acc_kind_in), .acc_base_in(acc_base_in), .acc_disp_in(acc_disp_in),
    .mem_addr_out(mem_addr_out), .rom_sel_out(rom_sel_out), .ram_sel_out(ram_sel_out),
    .periph_sel_out(periph_sel_out), .ext_sel_out(ext_sel_out),
    .ext_area_out(ext_area_out), .mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out),
    .prohibited_out(prohibited_out), .fetch_fault_out(fetch_fault_out),
    .pc_out(pc_out), .call_table_base_pointer_out(call_table_base_pointer_out), .pin_func_out(pin_func_out));
  core_access_model core_u (.clk_in(clk_in), .acc_valid_out(acc_valid_in),
    .acc_kind_out(acc_kind_in), .acc_base_out(acc_base_in), .acc_disp_out(acc_disp_in));
  // verdict and end of run
  task automatic end_sim;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // compare one value
  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (e !== g) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // cut a hang short
  always @(posedge clk_in) begin
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  // register port cycles
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 chk("reg_rdata", e, reg_rdata_out);
  endtask
  // expected {rom,ram,periph,ext[3:0],area,rd,wr,prohib,fault}
  function automatic logic [11:0] expv(logic [1:0] k, logic [25:0] a, logic [1:0] cfg,
                                       logic pin);
    logic [11:0] v;
    int i;
    v = '0;
    if (k == 2'b11) return v;
    if (a <= ROM_TOP) begin
      if (k == 2'b10) v[4] = 1'b1;
      else if (a <= (cfg[1] ? ROM_LIM_96K : ROM_LIM_128K)) v[11] = 1'b1;
      else v[1] = 1'b1;
    end else if (a <= EXT_TOP) begin
      i = a < CS1_BASE ? 0 : a < CS2_BASE ? 1 : a < CS3_BASE ? 2 : 3;
      if (!pin || (i > 1 && !cfg[0])) v[1] = 1'b1;
      else v[5+i] = 1'b1;
      v[4] = !v[1];
    end else if (a < RAM_BASE) v[1] = 1'b1;
    else if (a < PERIPH_BASE) v[10] = 1'b1;
    else if (k == 2'b00) v[1:0] = 2'b11;
    else v[9] = 1'b1;
    if (v[1:0] == 2'b00) begin
      v[3] = (k != 2'b10);
      v[2] = (k == 2'b10);
    end
    return v;
  endfunction
  // run accesses back to back, checking each one the cycle after
  task automatic run(input int n, input logic [1:0] cfg, input logic pin, input bit rnd);
    logic [1:0] k, pk;
    logic [25:0] a, pa;
    logic [31:0] b;
    logic pv;
    logic [11:0] ev;
    pv = 0;
    for (int j = 0; j <= n; j++) begin
      k = rnd ? 2'($random(seed)) : 2'(j % 3);
      a = ($random(seed) & 1) ? pool[$unsigned($random(seed)) % 20] : 26'($random(seed));
      if (!rnd) a = pool[j % 20];
      b = $random(seed);
      if (j < n) core_u.put(1'b1, k, b, {6'($random(seed)), a} - b);
      else core_u.put(1'b0, 2'b11, b, b);
      #1;
      if (pv) begin
        chk("region", 32'(expv(pk, pa, cfg, pin)), 32'({rom_sel_out, ram_sel_out,
            periph_sel_out, ext_sel_out, ext_area_out, mem_rd_out, mem_wr_out,
            prohibited_out, fetch_fault_out}));
        if (pk != 2'b11) chk("mem_addr", 32'(pa), 32'(mem_addr_out));
        ev = expv(pk, pa, cfg, pin);
        if (pk == 2'b00 && !ev[0]) pc_exp = {6'h00, pa};
        chk("pc", pc_exp, pc_out);
      end
      pv = 1;
      pk = k;
      pa = a;
    end
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clk_in);
    rst_b_in <= 1'b1;
    #1 chk("pc_rst", RESET_ENTRY, pc_out);
    chk("pins_rst", 32'(PINSEL_RESET), 32'(pin_func_out));
    rd(REG_CALL_TABLE_BASE_POINTER_OFF, CALL_TABLE_BASE_POINTER_RESET);
    wr(REG_CALL_TABLE_BASE_POINTER_OFF, 32'hffff_ffff);
    rd(REG_CALL_TABLE_BASE_POINTER_OFF, 32'h03ff_fffe);
    chk("call_table_base_pointer", 32'h03ff_fffe, call_table_base_pointer_out);
    wr(REG_CALL_TABLE_BASE_POINTER_OFF, 32'h0000_1235);
    rd(REG_CALL_TABLE_BASE_POINTER_OFF, 32'h0000_1234);
    wr(4'hf, 32'hffff_ffff);
    rd(4'hf, 32'h0000_0000);
    run(40, 2'b00, 1'b0, 0);
    wr(REG_PINSEL_OFF, 32'h0000_001f);
    rd(REG_PINSEL_OFF, 32'h0000_001f);
    chk("pins", 32'h0000_001f, 32'(pin_func_out));
    // wrap from top of program space to zero, then rom into external
    core_u.put(1'b1, 2'b00, 32'h03ff_fffe, 32'h0000_0002);
    core_u.put(1'b1, 2'b00, 32'h000f_fffe, 32'h0000_0000);
    #1 chk("pc_wrap", 32'h0000_0000, pc_out);
    core_u.put(1'b1, 2'b00, 32'h0010_0000, 32'h0000_0000);
    #1 chk("pc_seq", 32'h000f_fffe, pc_out);
    // data read through a high image with no displacement
    core_u.put(1'b1, 2'b01, 32'hfc00_0010, 32'h0000_0000);
    #1 chk("pc_ext", 32'h0010_0000, pc_out);
    chk("ext_sel", 32'h0000_0001, 32'(ext_sel_out));
    core_u.put(1'b0, 2'b11, 32'h0, 32'h0);
    #1 chk("image_addr", 32'h0000_0010, 32'(mem_addr_out));
    chk("image_rom", 32'h0000_0001, 32'(rom_sel_out));
    pc_exp = 32'h0010_0000;
    rd(REG_PC_OFF, pc_exp);
    // sticky fault from the port-mode run, last region rom; write one clears
    rd(REG_STATUS_OFF, 32'h0000_0101);
    wr(REG_STATUS_OFF, 32'h0000_0100);
    rd(REG_STATUS_OFF, 32'h0000_0001);
    @(posedge clk_in);
    #1 chk("rdata_idle", 32'h0000_0000, reg_rdata_out);
    for (int c = 0; c < 4; c++) begin
      wr(REG_CFG_OFF, 32'(c));
      run(20, 2'(c), 1'b1, 0);
      run(150, 2'(c), 1'b1, 1);
    end
    end_sim();
  end
endmodule // tb_cpu_address_map_decoder
`default_nettype wire
